/* File: logic/lmcr_pkg.sv */
//----------------------------------------------------------------
// Behaviour
// - 3-bit timeout select picks 162/325/650/1.3ms or 10.25/20.5/41/82us.
// - Link detect drops when the selected timeout passes without reverse traffic.
// - Two 8-bit scratch mailboxes, reset A5h and 5Ah, plain read/write.
// - Route 0000 disables remote irq; 0001 splits port 0/port 1 irqs.
// - Codes 10xx to general pins 0-3, 11xx to alternate pins; 001x,01xx reserved.
// - Several links, not dual link: remote irq combines both ports.
// - Low line-size register holds pixel count bits 7:0 for the splitter.
// - Combined line size defaults to 1280 pixels (0x500).
// - Same line size serves as 2D width in dual-input left/right mode.
// - Line-size bits 12:8 live in a 5-bit field resetting to 5h.
//----------------------------------------------------------------
package lmcr_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_LINK_LOSS_TIMEOUT_CONTROL = 8'h26;
  localparam logic [7:0] ADDR_SCRATCH_MAILBOX_A = 8'h2E;
  localparam logic [7:0] ADDR_SCRATCH_MAILBOX_B = 8'h2F;
  localparam logic [7:0] ADDR_REMOTE_IRQ_ROUTING = 8'h30;
  localparam logic [7:0] ADDR_SPLIT_LINE_WIDTH_LOW = 8'h32;
  localparam logic [7:0] ADDR_SPLIT_LINE_WIDTH_HIGH = 8'h33;

  // Reset values
  localparam logic [2:0] RST_TIMEOUT_SELECT = 3'h0;
  localparam logic [7:0] RST_SCRATCH_MAILBOX_A = 8'hA5;
  localparam logic [7:0] RST_SCRATCH_MAILBOX_B = 8'h5A;
  localparam logic [3:0] RST_ROUTE_SELECT = 4'h0;
  localparam logic [7:0] RST_LINE_WIDTH_LOW = 8'h00;
  localparam logic [4:0] RST_LINE_WIDTH_HIGH = 5'h05;

  // Field widths and positions
  localparam int TIMEOUT_SELECT_W = 3;
  localparam int ROUTE_SELECT_W = 4;
  localparam int LINE_WIDTH_HIGH_W = 5;
  localparam int LINE_WIDTH_W = 13;
  localparam logic [12:0] LINE_WIDTH_MAX = 13'h1000;

  // Route select codes
  localparam logic [3:0] ROUTE_OFF = 4'h0;
  localparam logic [3:0] ROUTE_SPLIT = 4'h1;
  localparam logic [1:0] ROUTE_GENERAL = 2'h2;
  localparam logic [1:0] ROUTE_ALTERNATE = 2'h3;

  // Link-detect timeouts, in ns
  localparam int CLK_PERIOD_NS = 100;
  localparam int T_LD_162MS_NS = 162000000;
  localparam int T_LD_325MS_NS = 325000000;
  localparam int T_LD_650MS_NS = 650000000;
  localparam int T_LD_1P3MS_NS = 1300000;
  localparam int T_LD_10P25US_NS = 10250;
  localparam int T_LD_20P5US_NS = 20500;
  localparam int T_LD_41US_NS = 41000;
  localparam int T_LD_82US_NS = 82000;

  // Least times round up to whole cycles
  function automatic int ns_to_cycles(input int t_ns);
    ns_to_cycles = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  endfunction : ns_to_cycles

  localparam int LD_CYC_162MS = ns_to_cycles(T_LD_162MS_NS);
  localparam int LD_CYC_325MS = ns_to_cycles(T_LD_325MS_NS);
  localparam int LD_CYC_650MS = ns_to_cycles(T_LD_650MS_NS);
  localparam int LD_CYC_1P3MS = ns_to_cycles(T_LD_1P3MS_NS);
  localparam int LD_CYC_10P25US = ns_to_cycles(T_LD_10P25US_NS);
  localparam int LD_CYC_20P5US = ns_to_cycles(T_LD_20P5US_NS);
  localparam int LD_CYC_41US = ns_to_cycles(T_LD_41US_NS);
  localparam int LD_CYC_82US = ns_to_cycles(T_LD_82US_NS);
  localparam int LD_CNT_W = 24;
  localparam logic [23:0] LD_CNT_ZERO = 24'h000000;

  typedef enum logic [0:0] {
    LMCR_LINK_DOWN = 1'b0,
    LMCR_LINK_UP = 1'b1
  } lmcr_link_state_t;

endpackage : lmcr_pkg

/* File: logic/lmcr_irq_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface lmcr_irq_if;
  logic [3:0] route_select;
  logic irq_port0;
  logic irq_port1;
  logic port1_active;
  logic dual_link;
  logic local_irq;
  logic remote_pin;
  logic local_pin;
  logic [3:0] general_out;
  logic [3:0] general_oe;
  logic [3:0] alternate_out;
  logic [3:0] alternate_oe;

  modport ctl (
    output route_select, irq_port0, irq_port1, port1_active, dual_link, local_irq,
    input remote_pin, local_pin, general_out, general_oe, alternate_out, alternate_oe
  );
  modport router (
    input route_select, irq_port0, irq_port1, port1_active, dual_link, local_irq,
    output remote_pin, local_pin, general_out, general_oe, alternate_out, alternate_oe
  );
endinterface : lmcr_irq_if
`default_nettype wire

/* File: logic/lmcr_link_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module lmcr_link_timer
  import lmcr_pkg::*;
#(
  parameter int CYC_162MS = LD_CYC_162MS,
  parameter int CYC_325MS = LD_CYC_325MS,
  parameter int CYC_650MS = LD_CYC_650MS,
  parameter int CYC_1P3MS = LD_CYC_1P3MS
)
(
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, low
  input wire logic [2:0] timeout_select, // Timeout code
  input wire logic frame_valid, // Good reverse frame
  output logic link_detect // Link present
);

  //--------------------------------------------------------------
  // Timeout decode
  //--------------------------------------------------------------
  function automatic logic [23:0] timeout_cycles(input logic [2:0] sel);
    int n;
    n = 0;
    case (sel)
      3'h0: n = CYC_162MS;
      3'h1: n = CYC_325MS;
      3'h2: n = CYC_650MS;
      3'h3: n = CYC_1P3MS;
      3'h4: n = LD_CYC_10P25US;
      3'h5: n = LD_CYC_20P5US;
      3'h6: n = LD_CYC_41US;
      default: n = LD_CYC_82US;
    endcase
    timeout_cycles = n[23:0];
  endfunction : timeout_cycles

  lmcr_link_state_t state;
  logic [23:0] cnt;
  logic [23:0] limit;

  assign limit = timeout_cycles(timeout_select);

  //--------------------------------------------------------------
  // Silence counter
  //--------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt <= LD_CNT_ZERO;
    else if (frame_valid)
      cnt <= LD_CNT_ZERO;
    else if (state == LMCR_LINK_UP)
      cnt <= cnt + 24'h000001;
    else
      cnt <= LD_CNT_ZERO;
  end

  //--------------------------------------------------------------
  // Link state
  //--------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      state <= LMCR_LINK_DOWN;
    else
    begin
      case (state)
        LMCR_LINK_DOWN:
          if (frame_valid)
            state <= LMCR_LINK_UP;
        LMCR_LINK_UP:
          if (!frame_valid && (cnt + 24'h000001 >= limit))
            state <= LMCR_LINK_DOWN;
        default:
          state <= LMCR_LINK_DOWN;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      link_detect <= 1'b0;
    else if (frame_valid)
      link_detect <= 1'b1;
    else if (state == LMCR_LINK_UP && (cnt + 24'h000001 >= limit))
      link_detect <= 1'b0;
  end

endmodule : lmcr_link_timer
`default_nettype wire

/* File: logic/lmcr_irq_router.sv */
`timescale 1ns/1ps
`default_nettype none
module lmcr_irq_router
  import lmcr_pkg::*;
(
  input wire logic clk, // Core clock
  input wire logic rst_n, // Async reset, low
  lmcr_irq_if.router irq // Routing signals
);

  logic combined;
  logic [1:0] pin_index;
  logic [1:0] group;

  //--------------------------------------------------------------
  // Source selection
  //--------------------------------------------------------------
  // Port 1 only contributes when it is a separate link
  assign combined = irq.irq_port0 |
    (irq.irq_port1 & irq.port1_active & ~irq.dual_link);
  assign pin_index = irq.route_select[1:0];
  assign group = irq.route_select[3:2];

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq.remote_pin <= 1'b0;
      irq.local_pin <= 1'b0;
    end
    else if (irq.route_select == ROUTE_SPLIT)
    begin
      irq.remote_pin <= irq.irq_port0;
      irq.local_pin <= irq.local_irq | irq.irq_port1;
    end
    else
    begin
      // Off and reserved codes leave the remote path idle
      irq.remote_pin <= 1'b0;
      irq.local_pin <= irq.local_irq;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq.general_out <= 4'h0;
      irq.general_oe <= 4'h0;
      irq.alternate_out <= 4'h0;
      irq.alternate_oe <= 4'h0;
    end
    else
    begin
      irq.general_out <= 4'h0;
      irq.general_oe <= 4'h0;
      irq.alternate_out <= 4'h0;
      irq.alternate_oe <= 4'h0;
      case (group)
        ROUTE_GENERAL:
        begin
          irq.general_out[pin_index] <= combined;
          irq.general_oe[pin_index] <= 1'b1;
        end
        ROUTE_ALTERNATE:
        begin
          irq.alternate_out[pin_index] <= combined;
          irq.alternate_oe[pin_index] <= 1'b1;
        end
        default:
        begin
          irq.general_oe <= 4'h0;
        end
      endcase
    end
  end

endmodule : lmcr_irq_router
`default_nettype wire

/* File: logic/lmcr_top.sv */
`timescale 1ns/1ps
`default_nettype none
module lmcr_top
  import lmcr_pkg::*;
#(
  parameter int CYC_162MS = LD_CYC_162MS, // 162 ms timeout
  parameter int CYC_325MS = LD_CYC_325MS, // 325 ms timeout
  parameter int CYC_650MS = LD_CYC_650MS, // 650 ms timeout
  parameter int CYC_1P3MS = LD_CYC_1P3MS // 1.3 ms timeout
)
(
  input wire logic CLK, // Core clock
  input wire logic RST_N, // Async reset, low
  input wire logic [7:0] REG_ADDR, // Register offset
  input wire logic [7:0] REG_WDATA, // Write data
  input wire logic REG_WE, // Write strobe
  input wire logic REG_RE, // Read strobe
  output logic [7:0] REG_RDATA, // Read data
  output logic REG_RVALID, // Read data valid
  input wire logic FRAME_VALID, // Good reverse frame
  output logic LINK_DETECT, // Link present
  input wire logic IRQ_PORT0, // Remote irq, port 0
  input wire logic IRQ_PORT1, // Remote irq, port 1
  input wire logic PORT1_ACTIVE, // Second link up
  input wire logic DUAL_LINK, // Dual link mode
  input wire logic LOCAL_IRQ, // Own interrupt
  output logic REMOTE_IRQ_PIN, // Remote irq pin
  output logic LOCAL_IRQ_PIN, // Local irq pin
  output logic [3:0] GENERAL_PIN_OUT, // General pins 0-3
  output logic [3:0] GENERAL_PIN_OE, // General pin enables
  output logic [3:0] ALTERNATE_PIN_OUT, // Alternate pins 0-3
  output logic [3:0] ALTERNATE_PIN_OE, // Alternate pin enables
  output logic [12:0] SPLIT_LINE_WIDTH, // Splitter line size
  output logic LINE_WIDTH_OVER // Line size above 4096
);

  //--------------------------------------------------------------
  // Register storage
  //--------------------------------------------------------------
  logic [2:0] timeout_select;
  logic [7:0] scratch_mailbox_a;
  logic [7:0] scratch_mailbox_b;
  logic [3:0] remote_irq_route_select;
  logic [7:0] split_line_width_low_bits;
  logic [4:0] split_line_width_high_bits;
  logic [12:0] next_line_width;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction : hit

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      timeout_select <= RST_TIMEOUT_SELECT;
    else if (REG_WE && hit(REG_ADDR, ADDR_LINK_LOSS_TIMEOUT_CONTROL))
      timeout_select <= REG_WDATA[2:0];
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      scratch_mailbox_a <= RST_SCRATCH_MAILBOX_A;
      scratch_mailbox_b <= RST_SCRATCH_MAILBOX_B;
    end
    else if (REG_WE)
    begin
      if (hit(REG_ADDR, ADDR_SCRATCH_MAILBOX_A))
        scratch_mailbox_a <= REG_WDATA;
      if (hit(REG_ADDR, ADDR_SCRATCH_MAILBOX_B))
        scratch_mailbox_b <= REG_WDATA;
    end
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      remote_irq_route_select <= RST_ROUTE_SELECT;
    else if (REG_WE && hit(REG_ADDR, ADDR_REMOTE_IRQ_ROUTING))
      remote_irq_route_select <= REG_WDATA[3:0];
  end

  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      split_line_width_low_bits <= RST_LINE_WIDTH_LOW;
      split_line_width_high_bits <= RST_LINE_WIDTH_HIGH;
    end
    else if (REG_WE)
    begin
      if (hit(REG_ADDR, ADDR_SPLIT_LINE_WIDTH_LOW))
        split_line_width_low_bits <= REG_WDATA;
      if (hit(REG_ADDR, ADDR_SPLIT_LINE_WIDTH_HIGH))
        split_line_width_high_bits <= REG_WDATA[4:0];
    end
  end

  //--------------------------------------------------------------
  // Splitter line size
  //--------------------------------------------------------------
  always_comb
  begin
    next_line_width = {split_line_width_high_bits, split_line_width_low_bits};
    if (REG_WE && hit(REG_ADDR, ADDR_SPLIT_LINE_WIDTH_LOW))
      next_line_width[7:0] = REG_WDATA;
    if (REG_WE && hit(REG_ADDR, ADDR_SPLIT_LINE_WIDTH_HIGH))
      next_line_width[12:8] = REG_WDATA[4:0];
  end

  // Registered copy feeds the splitter and the 2D width in left/right mode
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      SPLIT_LINE_WIDTH <= {RST_LINE_WIDTH_HIGH, RST_LINE_WIDTH_LOW};
    else
      SPLIT_LINE_WIDTH <= next_line_width;
  end

  // Flags a size software should not use; value is still applied
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      LINE_WIDTH_OVER <= 1'b0;
    else
      LINE_WIDTH_OVER <= (next_line_width > LINE_WIDTH_MAX);
  end

  //--------------------------------------------------------------
  // Read port
  //--------------------------------------------------------------
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      REG_RDATA <= 8'h00;
      REG_RVALID <= 1'b0;
    end
    else
    begin
      REG_RVALID <= REG_RE;
      if (REG_RE)
      begin
        case (REG_ADDR)
          ADDR_LINK_LOSS_TIMEOUT_CONTROL: REG_RDATA <= {5'h00, timeout_select};
          ADDR_SCRATCH_MAILBOX_A: REG_RDATA <= scratch_mailbox_a;
          ADDR_SCRATCH_MAILBOX_B: REG_RDATA <= scratch_mailbox_b;
          ADDR_REMOTE_IRQ_ROUTING: REG_RDATA <= {4'h0, remote_irq_route_select};
          ADDR_SPLIT_LINE_WIDTH_LOW: REG_RDATA <= split_line_width_low_bits;
          ADDR_SPLIT_LINE_WIDTH_HIGH: REG_RDATA <= {3'h0, split_line_width_high_bits};
          default: REG_RDATA <= 8'h00;
        endcase
      end
    end
  end

  //--------------------------------------------------------------
  // Link detect timer
  //--------------------------------------------------------------
  lmcr_link_timer #(
    .CYC_162MS(CYC_162MS),
    .CYC_325MS(CYC_325MS),
    .CYC_650MS(CYC_650MS),
    .CYC_1P3MS(CYC_1P3MS)
  ) u_timer (
    .clk(CLK),
    .rst_n(RST_N),
    .timeout_select(timeout_select),
    .frame_valid(FRAME_VALID),
    .link_detect(LINK_DETECT)
  );

  //--------------------------------------------------------------
  // Remote interrupt routing
  //--------------------------------------------------------------
  lmcr_irq_if irq_bus ();

  assign irq_bus.route_select = remote_irq_route_select;
  assign irq_bus.irq_port0 = IRQ_PORT0;
  assign irq_bus.irq_port1 = IRQ_PORT1;
  assign irq_bus.port1_active = PORT1_ACTIVE;
  assign irq_bus.dual_link = DUAL_LINK;
  assign irq_bus.local_irq = LOCAL_IRQ;
  assign REMOTE_IRQ_PIN = irq_bus.remote_pin;
  assign LOCAL_IRQ_PIN = irq_bus.local_pin;
  assign GENERAL_PIN_OUT = irq_bus.general_out;
  assign GENERAL_PIN_OE = irq_bus.general_oe;
  assign ALTERNATE_PIN_OUT = irq_bus.alternate_out;
  assign ALTERNATE_PIN_OE = irq_bus.alternate_oe;

  lmcr_irq_router u_router (
    .clk(CLK),
    .rst_n(RST_N),
    .irq(irq_bus.router)
  );

endmodule : lmcr_top
`default_nettype wire

/* File: sim/lmcr_top_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module lmcr_top_sva
  import lmcr_pkg::*;
#(
  parameter int CYC_162MS = LD_CYC_162MS, // 162 ms count
  parameter int CYC_325MS = LD_CYC_325MS, // 325 ms count
  parameter int CYC_650MS = LD_CYC_650MS, // 650 ms count
  parameter int CYC_1P3MS = LD_CYC_1P3MS // 1.3 ms count
)
(
  input wire logic CLK, // Clock
  input wire logic RST_N, // Reset
  input wire logic [7:0] REG_ADDR, // Offset
  input wire logic [7:0] REG_WDATA, // Write data
  input wire logic REG_WE, // Write
  input wire logic REG_RE, // Read
  input wire logic [7:0] REG_RDATA, // Read data
  input wire logic REG_RVALID, // Read valid
  input wire logic FRAME_VALID, // Frame
  input wire logic LINK_DETECT, // Link
  input wire logic IRQ_PORT0, // Irq 0
  input wire logic IRQ_PORT1, // Irq 1
  input wire logic PORT1_ACTIVE, // Port 1 up
  input wire logic DUAL_LINK, // Dual link
  input wire logic LOCAL_IRQ, // Own irq
  input wire logic REMOTE_IRQ_PIN, // Remote pin
  input wire logic LOCAL_IRQ_PIN, // Local pin
  input wire logic [3:0] GENERAL_PIN_OUT, // General out
  input wire logic [3:0] GENERAL_PIN_OE, // General oe
  input wire logic [3:0] ALTERNATE_PIN_OUT, // Alternate out
  input wire logic [3:0] ALTERNATE_PIN_OE, // Alternate oe
  input wire logic [12:0] SPLIT_LINE_WIDTH // Line size
);
  // ------
  // Shadow state
  // ------
  localparam int LIM = 820 + CYC_162MS + CYC_325MS + CYC_650MS + CYC_1P3MS;
  logic [3:0] route;
  logic [23:0] idle;
  logic comb;
  assign comb = IRQ_PORT0 | (IRQ_PORT1 & PORT1_ACTIVE & ~DUAL_LINK);
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      route <= 4'h0;
    else if (REG_WE && REG_ADDR == 8'h30)
      route <= REG_WDATA[3:0];
  end
  always_ff @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      idle <= 24'h000000;
    else if (FRAME_VALID)
      idle <= 24'h000000;
    else if (idle != 24'hFFFFFF)
      idle <= idle + 24'h000001;
  end
  default clocking @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  // ------
  // Properties
  // ------
  property p_rv;
    REG_RE |=> REG_RVALID;
  endproperty
  a_rv: assert property (p_rv) else $error("read valid missing");
  property p_unmap;
    REG_RE && !(REG_ADDR inside {8'h26, 8'h2E, 8'h2F, 8'h30, 8'h32, 8'h33})
      |=> REG_RDATA == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_ld_up;
    FRAME_VALID |=> LINK_DETECT;
  endproperty
  a_ld_up: assert property (p_ld_up) else $error("link not up after frame");
  property p_ld_rise;
    !LINK_DETECT && !FRAME_VALID |=> !LINK_DETECT;
  endproperty
  a_ld_rise: assert property (p_ld_rise) else $error("link up without frame");
  property p_ld_drop;
    idle >= LIM |-> !LINK_DETECT;
  endproperty
  a_ld_drop: assert property (p_ld_drop) else $error("link kept too long");
  property p_off;
    !route[3] && route != 4'h1 && $stable(route)
      |=> GENERAL_PIN_OE == 4'h0 && ALTERNATE_PIN_OE == 4'h0 && !REMOTE_IRQ_PIN;
  endproperty
  a_off: assert property (p_off) else $error("disabled route drives");
  property p_split;
    route == 4'h1 && $stable(route) |=> REMOTE_IRQ_PIN == $past(IRQ_PORT0)
      && LOCAL_IRQ_PIN == ($past(LOCAL_IRQ) | $past(IRQ_PORT1));
  endproperty
  a_split: assert property (p_split) else $error("split route wrong");
  property p_gen;
    route[3:2] == 2'b10 && $stable(route) |=> GENERAL_PIN_OE == (4'h1 << $past(route[1:0]))
      && GENERAL_PIN_OUT == ({4{$past(comb)}} & (4'h1 << $past(route[1:0])));
  endproperty
  a_gen: assert property (p_gen) else $error("general route wrong");
  property p_alt;
    route[3:2] == 2'b11 && $stable(route) |=> ALTERNATE_PIN_OE == (4'h1 << $past(route[1:0]))
      && ALTERNATE_PIN_OUT == ({4{$past(comb)}} & (4'h1 << $past(route[1:0])));
  endproperty
  a_alt: assert property (p_alt) else $error("alternate route wrong");
  property p_wlo;
    REG_WE && REG_ADDR == 8'h32 |=> SPLIT_LINE_WIDTH[7:0] == $past(REG_WDATA);
  endproperty
  a_wlo: assert property (p_wlo) else $error("line size low wrong");
  property p_whi;
    REG_WE && REG_ADDR == 8'h33
      |=> {3'h0, SPLIT_LINE_WIDTH[12:8]} == ($past(REG_WDATA) & 8'h1F);
  endproperty
  a_whi: assert property (p_whi) else $error("line size high wrong");
endmodule : lmcr_top_sva
bind lmcr_top lmcr_top_sva #(.CYC_162MS(CYC_162MS), .CYC_325MS(CYC_325MS),
  .CYC_650MS(CYC_650MS), .CYC_1P3MS(CYC_1P3MS)) lmcr_top_sva_i (.CLK(CLK), .RST_N(RST_N),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RE(REG_RE),
  .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .FRAME_VALID(FRAME_VALID),
  .LINK_DETECT(LINK_DETECT), .IRQ_PORT0(IRQ_PORT0), .IRQ_PORT1(IRQ_PORT1),
  .PORT1_ACTIVE(PORT1_ACTIVE), .DUAL_LINK(DUAL_LINK), .LOCAL_IRQ(LOCAL_IRQ),
  .REMOTE_IRQ_PIN(REMOTE_IRQ_PIN), .LOCAL_IRQ_PIN(LOCAL_IRQ_PIN),
  .GENERAL_PIN_OUT(GENERAL_PIN_OUT), .GENERAL_PIN_OE(GENERAL_PIN_OE),
  .ALTERNATE_PIN_OUT(ALTERNATE_PIN_OUT), .ALTERNATE_PIN_OE(ALTERNATE_PIN_OE),
  .SPLIT_LINE_WIDTH(SPLIT_LINE_WIDTH));
`default_nettype wire

/* File: sim/lmcr_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
module lmcr_far_end
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset, low
  input wire logic run, // Send frames
  input wire logic [9:0] gap, // Frame spacing
  output logic frame_valid, // Good frame
  output logic irq0, // Port 0 irq
  output logic irq1 // Port 1 irq
);
  logic [9:0] cnt;
  // ------
  // Reverse frames, one cycle each
  // ------
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      frame_valid <= 1'b0;
      cnt <= 10'h000;
    end
    else if (run && cnt == 10'h000)
    begin
      frame_valid <= 1'b1;
      cnt <= gap;
    end
    else
    begin
      frame_valid <= 1'b0;
      cnt <= (cnt == 10'h000) ? cnt : cnt - 10'h001;
    end
  end
  // Remote irq levels wander freely
  always_ff @(posedge clk)
  begin
    irq0 <= 1'($urandom);
    irq1 <= 1'($urandom);
  end
endmodule : lmcr_far_end
`default_nettype wire

/* File: sim/tb_lmcr_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) \
  begin \
    checks_done++; \
    if ((a) !== (b)) \
    begin \
      errors++; \
      $display("unexpected at %0t: %h, wanted %h", $time, a, b); \
    end \
  end
module tb_lmcr_top;
  import lmcr_pkg::*;
  localparam int T0 = 40;
  localparam int T1 = 50;
  localparam int T2 = 60;
  localparam int T3 = 30;
  int n[8] = '{T0, T1, T2, T3, LD_CYC_10P25US, LD_CYC_20P5US, LD_CYC_41US, LD_CYC_82US};
  int errors = 0;
  int checks_done = 0;
  logic clk, rst_n, we, re, p1_act, dual, loc_irq, run, fv, irq0, irq1;
  logic rvalid, link_det, rem_pin, over;
  logic [7:0] addr, wdata, rdata, exp_v, d0, d1;
  logic [9:0] gap;
  logic [3:0] gen_oe, alt_oe;
  logic [12:0] width, v;
  logic [7:0] expq[$];
  lmcr_top #(.CYC_162MS(T0), .CYC_325MS(T1), .CYC_650MS(T2), .CYC_1P3MS(T3)) lmcr_top_i (
    .CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WE(we),
    .REG_RE(re), .REG_RDATA(rdata), .REG_RVALID(rvalid), .FRAME_VALID(fv),
    .LINK_DETECT(link_det), .IRQ_PORT0(irq0), .IRQ_PORT1(irq1), .PORT1_ACTIVE(p1_act),
    .DUAL_LINK(dual), .LOCAL_IRQ(loc_irq), .REMOTE_IRQ_PIN(rem_pin), .LOCAL_IRQ_PIN(),
    .GENERAL_PIN_OUT(), .GENERAL_PIN_OE(gen_oe), .ALTERNATE_PIN_OUT(),
    .ALTERNATE_PIN_OE(alt_oe), .SPLIT_LINE_WIDTH(width), .LINE_WIDTH_OVER(over));
  lmcr_far_end lmcr_far_end_i (.clk(clk), .rst_n(rst_n), .run(run), .gap(gap),
    .frame_valid(fv), .irq0(irq0), .irq1(irq1));
  always #50 clk = ~clk;
  // ------
  // Bus tasks
  // ------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    we <= 1'b1;
    @(posedge clk);
    we <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    re <= 1'b1;
    expq.push_back(e);
    @(posedge clk);
    re <= 1'b0;
  endtask : rd
  task automatic tick(input int k);
    repeat (k) @(posedge clk);
    #1;
  endtask : tick
  task automatic report_and_stop();
    $display("checks %0d, mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : report_and_stop
  // Read results against the oldest note
  always @(posedge clk)
  begin
    if (rvalid === 1'b1)
    begin
      exp_v = (expq.size() > 0) ? expq.pop_front() : 8'hXX;
      `CHK(rdata, exp_v)
    end
  end
  initial
  begin
    repeat (60000) @(posedge clk);
    errors++;
    $display("unexpected at %0t: run too long", $time);
    report_and_stop();
  end
  // ------
  // Main sequence
  // ------
  initial
  begin
    {clk, rst_n, we, re, p1_act, dual, loc_irq, run} = 8'h00;
    addr = 8'h00;
    wdata = 8'h00;
    gap = 10'd20;
    void'($urandom(32'h67AA9271));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    `CHK(width, 13'h0500)
    `CHK(link_det, 1'b0)
    rd(8'h26, 8'h00);
    rd(8'h2E, 8'hA5);
    rd(8'h2F, 8'h5A);
    rd(8'h30, 8'h00);
    rd(8'h32, 8'h00);
    rd(8'h33, 8'h05);
    rd(8'h31, 8'h00);
    $display("test resets done");
    d0 = 8'($urandom);
    d1 = 8'($urandom);
    wr(8'h2E, d0);
    wr(8'h2F, d1);
    wr(8'h31, 8'hFF);
    rd(8'h2E, d0);
    rd(8'h2F, d1);
    rd(8'h31, 8'h00);
    wr(8'h26, 8'hFF);
    rd(8'h26, 8'h07);
    wr(8'h30, 8'hFF);
    rd(8'h30, 8'h0F);
    wr(8'h33, 8'hFF);
    rd(8'h33, 8'h1F);
    for (int i = 0; i < 3; i++)
    begin
      v = (i == 0) ? 13'h1000 : (i == 1) ? 13'h1001 : 13'($urandom);
      wr(8'h32, v[7:0]);
      wr(8'h33, {3'h0, v[12:8]});
      tick(1);
      `CHK(width, v)
      `CHK(over, v > 13'h1000)
    end
    $display("test registers done");
    for (int c = 0; c < 8; c++)
    begin
      wr(8'h26, 8'(c));
      @(posedge clk);
      run <= 1'b1;
      @(posedge clk);
      run <= 1'b0;
      tick(n[c]);
      `CHK(link_det, 1'b1)
      tick(1);
      `CHK(link_det, 1'b0)
    end
    wr(8'h26, 8'h00);
    @(posedge clk);
    run <= 1'b1;
    tick(4);
    for (int i = 0; i < 200; i++)
    begin
      tick(1);
      `CHK(link_det, 1'b1)
    end
    @(posedge clk);
    run <= 1'b0;
    tick(T0 + 22);
    `CHK(link_det, 1'b0)
    $display("test link detect done");
    for (int c = 0; c < 16; c++)
    begin
      wr(8'h30, 8'(c));
      repeat (20)
      begin
        @(posedge clk);
        p1_act <= 1'($urandom);
        dual <= 1'($urandom);
        loc_irq <= 1'($urandom);
      end
      #1;
      `CHK(gen_oe, (c[3:2] == 2'b10) ? (4'h1 << c[1:0]) : 4'h0)
      `CHK(alt_oe, (c[3:2] == 2'b11) ? (4'h1 << c[1:0]) : 4'h0)
      if (c < 8 && c != 1)
        `CHK(rem_pin, 1'b0)
    end
    $display("test routing done");
    for (int i = 0; i < 10 && expq.size() > 0; i++)
      @(posedge clk);
    if (expq.size() > 0)
      errors++;
    report_and_stop();
  end
endmodule : tb_lmcr_top
`default_nettype wire
